/* File: inc/hbel_pkg.sv */
package hbel_pkg;

    // ********************************************
    // Register byte offsets
    // ********************************************
    localparam logic [7:0] HBEL_SEL_OFS = 8'h00;
    localparam logic [7:0] HBEL_ENG_FREQ_OFS = 8'h04;
    localparam logic [7:0] HBEL_ENG_TIME_OFS = 8'h08;
    localparam logic [7:0] HBEL_REL_FREQ_OFS = 8'h0C;
    localparam logic [7:0] HBEL_REL_TIME_OFS = 8'h10;
    localparam logic [7:0] HBEL_REL_CUR_OFS = 8'h14;
    localparam logic [7:0] HBEL_REL_TRQ_OFS = 8'h18;
    localparam logic [7:0] HBEL_STOP_FREQ_OFS = 8'h1C;
    localparam logic [7:0] HBEL_STATUS_OFS = 8'h20;

    // ********************************************
    // Selection word fields
    // ********************************************
    localparam int HBEL_SPD_SRC_BIT = 0;
    localparam int HBEL_QUICK_BIT = 2;
    localparam int HBEL_THR_SRC_BIT = 3;
    localparam int HBEL_RUN_GATE_BIT = 4;
    localparam logic [4:0] HBEL_SEL_MASK = 5'h1D;

    // ********************************************
    // Values after reset (0.1 Hz, 0.1 s and percent units)
    // ********************************************
    localparam logic [4:0] HBEL_SEL_RST = 5'h00;
    localparam logic [15:0] HBEL_ENG_FREQ_RST = 16'h000A;
    localparam logic [5:0] HBEL_ENG_TIME_RST = 6'h0A;
    localparam logic [15:0] HBEL_REL_FREQ_RST = 16'h000A;
    localparam logic [5:0] HBEL_REL_TIME_RST = 6'h0A;
    localparam logic [8:0] HBEL_REL_CUR_RST = 9'h064;
    localparam logic [8:0] HBEL_REL_TRQ_RST = 9'h064;
    localparam logic [15:0] HBEL_STOP_FREQ_RST = 16'h0005;

    // ********************************************
    // Timing
    // ********************************************
    localparam int HBEL_CLK_HZ = 20000000;
    localparam int HBEL_TICK_MS = 100;
    localparam int HBEL_TICK_CYCLES = HBEL_CLK_HZ / 1000 * HBEL_TICK_MS;
    localparam int HBEL_FILT_SHIFT = 4;

    localparam logic [1:0] HBEL_RESP_OKAY = 2'h0;
    localparam logic [1:0] HBEL_RESP_SLVERR = 2'h2;

    typedef enum logic {HBEL_ENGAGED, HBEL_RELEASED} hbel_state_t;

endpackage : hbel_pkg

/* File: hw/hbel_top.sv */
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
// Operation
// R1 - V/f: run off and frequency below engage level for engage time drops release.
// R2 - Vector: chosen speed below chosen threshold for engage time drops release.
// R3 - Speed source bit: 0 detected speed, 1 reference speed.
// R4 - Threshold source bit: 0 stop frequency, 1 engage frequency.
// R5 - Run gate bit: 0 regardless of run command, 1 only with run off.
// R6 - Output shutdown during engage count engages the brake at once.
// R7 - Only motor set one is sequenced; other sets hold the output on.
// R8 - Alarm or coast-stop shutdown switches the output on at once.
// R9 - Sensorless vector control should use reference speed as source.
// R10 - Forward/reverse switching applications should set the run gate bit.
// R11 - Current, frequency or torque above release level for release time releases.
// R12 - Current response bit: 0 filtered slow detection, 1 unfiltered quick detection.
// R13 - Engage timer restarts from zero whenever its condition lapses early.
module hbel_top
    import hbel_pkg::*;
#(
    parameter int TICK_CYCLES = HBEL_TICK_CYCLES
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Drive state, from control logic on aclk
    input wire logic run_cmd,
    input wire logic vector_mode,
    input wire logic output_shutdown,
    input wire logic alarm_trip,
    input wire logic coast_stop,
    input wire logic [1:0] motor_sel,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] ref_speed,
    input wire logic [15:0] det_speed,
    input wire logic [8:0] out_current,
    input wire logic [8:0] torque_cmd,
    // Brake
    output logic brake_release_output
);

    // ********************************************
    // Helpers
    // ********************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic elapsed(input logic [31:0] cnt, input logic [5:0] units);
        logic [39:0] lim;
        lim = 40'(units) * 40'(TICK_CYCLES);
        return 40'(cnt) >= lim;
    endfunction : elapsed

    // ********************************************
    // Register bus
    // ********************************************
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_full_q, w_full_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [4:0] sel_q;
    logic [15:0] eng_freq_q, rel_freq_q, stop_freq_q;
    logic [5:0] eng_time_q, rel_time_q;
    logic [8:0] rel_cur_q, rel_trq_q;
    logic [31:0] rd_word;
    logic rd_ok, wr_ok;

    wire aw_take = awvalid & awready_q;
    wire w_take = wvalid & wready_q;
    wire do_write = aw_full_q & w_full_q & ~bvalid_q;
    wire aw_full_d = (aw_full_q | aw_take) & ~do_write;
    wire w_full_d = (w_full_q | w_take) & ~do_write;
    wire ar_take = arvalid & arready_q;
    wire rvalid_d = ar_take | (rvalid_q & ~rready);
    wire bvalid_d = do_write | (bvalid_q & ~bready);
    wire [31:0] wr_word = wdata_q;

    hbel_state_t state_q, state_d;
    logic out_q, eng_busy, rel_busy;
    wire [31:0] status_word = {29'h0, rel_busy, eng_busy, out_q};

    assign wr_ok = (waddr_q == HBEL_SEL_OFS) || (waddr_q == HBEL_ENG_FREQ_OFS)
        || (waddr_q == HBEL_ENG_TIME_OFS) || (waddr_q == HBEL_REL_FREQ_OFS)
        || (waddr_q == HBEL_REL_TIME_OFS) || (waddr_q == HBEL_REL_CUR_OFS)
        || (waddr_q == HBEL_REL_TRQ_OFS) || (waddr_q == HBEL_STOP_FREQ_OFS);

    always_comb
    begin
        rd_ok = 1'b1;
        if (araddr == HBEL_SEL_OFS) rd_word = {27'h0, sel_q};
        else if (araddr == HBEL_ENG_FREQ_OFS) rd_word = {16'h0, eng_freq_q};
        else if (araddr == HBEL_ENG_TIME_OFS) rd_word = {26'h0, eng_time_q};
        else if (araddr == HBEL_REL_FREQ_OFS) rd_word = {16'h0, rel_freq_q};
        else if (araddr == HBEL_REL_TIME_OFS) rd_word = {26'h0, rel_time_q};
        else if (araddr == HBEL_REL_CUR_OFS) rd_word = {23'h0, rel_cur_q};
        else if (araddr == HBEL_REL_TRQ_OFS) rd_word = {23'h0, rel_trq_q};
        else if (araddr == HBEL_STOP_FREQ_OFS) rd_word = {16'h0, stop_freq_q};
        else if (araddr == HBEL_STATUS_OFS) rd_word = status_word;
        else
        begin
            rd_word = 32'h0;
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= HBEL_RESP_OKAY;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end
        else
        begin
            awready_q <= ~aw_full_d;
            wready_q <= ~w_full_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            bvalid_q <= bvalid_d;
            if (aw_take) waddr_q <= awaddr;
            if (w_take) wdata_q <= wdata;
            if (w_take) wstrb_q <= wstrb;
            if (do_write) bresp_q <= wr_ok ? HBEL_RESP_OKAY : HBEL_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= HBEL_RESP_OKAY;
        end
        else
        begin
            arready_q <= ~rvalid_d & ~ar_take;
            rvalid_q <= rvalid_d;
            if (ar_take) rdata_q <= rd_word;
            if (ar_take) rresp_q <= rd_ok ? HBEL_RESP_OKAY : HBEL_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_q <= HBEL_SEL_RST;
            eng_freq_q <= HBEL_ENG_FREQ_RST;
            eng_time_q <= HBEL_ENG_TIME_RST;
            rel_freq_q <= HBEL_REL_FREQ_RST;
            rel_time_q <= HBEL_REL_TIME_RST;
            rel_cur_q <= HBEL_REL_CUR_RST;
            rel_trq_q <= HBEL_REL_TRQ_RST;
            stop_freq_q <= HBEL_STOP_FREQ_RST;
        end
        else if (do_write)
        begin
            if (waddr_q == HBEL_SEL_OFS)
                sel_q <= 5'(merge({27'h0, sel_q}, wr_word, wstrb_q)) & HBEL_SEL_MASK;
            if (waddr_q == HBEL_ENG_FREQ_OFS)
                eng_freq_q <= 16'(merge({16'h0, eng_freq_q}, wr_word, wstrb_q));
            if (waddr_q == HBEL_ENG_TIME_OFS)
                eng_time_q <= 6'(merge({26'h0, eng_time_q}, wr_word, wstrb_q));
            if (waddr_q == HBEL_REL_FREQ_OFS)
                rel_freq_q <= 16'(merge({16'h0, rel_freq_q}, wr_word, wstrb_q));
            if (waddr_q == HBEL_REL_TIME_OFS)
                rel_time_q <= 6'(merge({26'h0, rel_time_q}, wr_word, wstrb_q));
            if (waddr_q == HBEL_REL_CUR_OFS)
                rel_cur_q <= 9'(merge({23'h0, rel_cur_q}, wr_word, wstrb_q));
            if (waddr_q == HBEL_REL_TRQ_OFS)
                rel_trq_q <= 9'(merge({23'h0, rel_trq_q}, wr_word, wstrb_q));
            if (waddr_q == HBEL_STOP_FREQ_OFS)
                stop_freq_q <= 16'(merge({16'h0, stop_freq_q}, wr_word, wstrb_q));
        end
    end

    // ********************************************
    // Brake sequencing
    // ********************************************
    logic [12:0] cur_filt_q;
    logic [31:0] eng_cnt_q, rel_cnt_q;

    // The slow path is a first-order lag, so release trails a rising current slightly.
    wire [8:0] cur_slow = cur_filt_q[12:4];
    wire [8:0] cur_seen = sel_q[HBEL_QUICK_BIT] ? out_current : cur_slow; // [R12]
    wire [12:0] cur_step = 13'(out_current) - (cur_filt_q >> HBEL_FILT_SHIFT);

    wire [15:0] eng_speed = sel_q[HBEL_SPD_SRC_BIT] ? ref_speed : det_speed; // [R3]
    wire [15:0] eng_thr = sel_q[HBEL_THR_SRC_BIT] ? eng_freq_q : stop_freq_q; // [R4]
    wire run_ok = sel_q[HBEL_RUN_GATE_BIT] ? ~run_cmd : 1'b1; // [R5]
    wire eng_cond_vf = ~run_cmd & (out_freq < eng_freq_q); // [R1]
    wire eng_cond_vec = (eng_speed < eng_thr) & run_ok; // [R2]
    wire eng_cond = vector_mode ? eng_cond_vec : eng_cond_vf;
    wire rel_level = vector_mode ? (torque_cmd > rel_trq_q) : (out_freq > rel_freq_q);
    wire rel_cond = (cur_seen > rel_cur_q) | rel_level; // [R11]
    wire force_on = alarm_trip | coast_stop | (motor_sel != 2'h0); // [R7] [R8]

    assign eng_busy = (state_q == HBEL_RELEASED) & eng_cond & ~force_on;
    assign rel_busy = (state_q == HBEL_ENGAGED) & rel_cond & ~force_on;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            HBEL_ENGAGED:
            begin
                if (rel_busy && elapsed(rel_cnt_q + 32'h1, rel_time_q)) // [R11]
                    state_d = HBEL_RELEASED;
            end
            HBEL_RELEASED:
            begin
                if (output_shutdown) // [R6]
                    state_d = HBEL_ENGAGED;
                else if (eng_busy && elapsed(eng_cnt_q + 32'h1, eng_time_q)) // [R1] [R2]
                    state_d = HBEL_ENGAGED;
            end
            default: state_d = HBEL_ENGAGED;
        endcase
        if (force_on)
            state_d = HBEL_RELEASED; // [R7] [R8]
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= HBEL_ENGAGED;
            out_q <= 1'b0;
            eng_cnt_q <= 32'h0;
            rel_cnt_q <= 32'h0;
            cur_filt_q <= 13'h0;
        end
        else
        begin
            state_q <= state_d;
            out_q <= (state_d == HBEL_RELEASED);
            eng_cnt_q <= eng_busy ? eng_cnt_q + 32'h1 : 32'h0; // [R13]
            rel_cnt_q <= rel_busy ? rel_cnt_q + 32'h1 : 32'h0;
            cur_filt_q <= cur_filt_q + cur_step;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign brake_release_output = out_q;

endmodule : hbel_top

/* File: bench/hbel_top_sva.sv */
`timescale 1ns/10ps
module hbel_top_sva
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // Drive state and brake
    input wire logic run_cmd,
    input wire logic vector_mode,
    input wire logic output_shutdown,
    input wire logic alarm_trip,
    input wire logic coast_stop,
    input wire logic [1:0] motor_sel,
    input wire logic brake_release_output
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire force_on = alarm_trip || coast_stop || motor_sel != 2'h0;
    property p_wr_lat;
        awvalid && awready && wvalid && wready && !bvalid |=> !awready ##1 bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write response late");
    property p_b_done;
        bvalid && bready |=> !bvalid && awready;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write response not closed");
    property p_rd_lat;
        arvalid && arready |=> rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_ar_busy;
        rvalid |-> !arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("read address taken while busy");
    property p_r_done;
        rvalid && rready |=> !rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read data not closed");
    property p_force;
        force_on |=> brake_release_output;
    endproperty
    a_force: assert property (p_force) else $error("brake output not forced on");
    property p_shut;
        output_shutdown && !force_on |=> !brake_release_output;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown did not engage brake");
    property p_vf_run;
        $fell(brake_release_output) && !$past(vector_mode) && !$past(output_shutdown)
            |-> !$past(run_cmd);
    endproperty
    a_vf_run: assert property (p_vf_run) else $error("engage with run command on");
endmodule : hbel_top_sva
bind hbel_top hbel_top_sva i_hbel_top_sva (.*);

/* File: bench/hbel_brake_model.sv */
`timescale 1ns/10ps
// Spring brake: the shoe lifts only after the release line has stood for a few
// cycles, so a short glitch on it never lets the load slip.
module hbel_brake_model
#(
    parameter int DLY = 2
)
(
    input wire logic aclk,
    input wire logic brake_release_output,
    output logic brake_held
);
    int cnt_q = 0;
    initial brake_held = 1'h1;
    always @(posedge aclk)
    begin
        cnt_q <= brake_release_output ? ((cnt_q < DLY) ? cnt_q + 1 : cnt_q) : 0;
        brake_held <= !(brake_release_output && cnt_q == DLY);
    end
endmodule : hbel_brake_model

/* File: bench/hbel_top_tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) \
    begin \
        check_count++; \
        if ((s) !== (e)) \
        begin \
            errors++; \
            $display("ERROR %s exp %0h got %0h", n, e, s); \
        end \
    end
module hbel_top_tb
    import hbel_pkg::*;
;
    // ****
    // Stimulus and reference model
    // ****
    localparam int TK = 4;
    localparam int N = 2 * TK;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, run_cmd = 1'h0, vector_mode = 1'h0;
    logic output_shutdown = 1'h0, alarm_trip = 1'h0, coast_stop = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, brake_release_output, brake_held;
    logic [1:0] motor_sel = 2'h0, bresp, rresp;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, lf = 32'h9579;
    logic [3:0] wstrb = 4'hF;
    logic [15:0] out_freq = 16'h0, ref_speed = 16'h0, det_speed = 16'h0;
    logic [8:0] out_current = 9'h0, torque_cmd = 9'h0;
    logic [31:0] rst [8] = '{32'(HBEL_SEL_RST), 32'(HBEL_ENG_FREQ_RST),
        32'(HBEL_ENG_TIME_RST), 32'(HBEL_REL_FREQ_RST), 32'(HBEL_REL_TIME_RST),
        32'(HBEL_REL_CUR_RST), 32'(HBEL_REL_TRQ_RST), 32'(HBEL_STOP_FREQ_RST)};
    int errors = 0, check_count = 0, ec = 0, rc = 0, sel = 0, cf = 0, spd, thr;
    bit m = 0, ce, cr, fo;
    hbel_top #(.TICK_CYCLES(TK)) i_hbel_top (.*);
    hbel_brake_model i_hbel_brake_model (.aclk(aclk),
        .brake_release_output(brake_release_output), .brake_held(brake_held));
    initial forever #25 aclk = ~aclk;
    function automatic int rnd(input int k);
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf % k;
    endfunction : rnd
    // Checks are taken well clear of the count boundaries, so the model need not
    // copy the design's exact register stage.
    always @(posedge aclk)
    begin
        spd = sel[0] ? ref_speed : det_speed;
        thr = sel[3] ? HBEL_ENG_FREQ_RST : HBEL_STOP_FREQ_RST;
        ce = vector_mode ? (spd < thr && !(sel[4] && run_cmd))
            : (!run_cmd && out_freq < HBEL_ENG_FREQ_RST);
        cr = (sel[2] ? out_current : cf / 16) > HBEL_REL_CUR_RST || (vector_mode ?
            torque_cmd > HBEL_REL_TRQ_RST : out_freq > HBEL_REL_FREQ_RST);
        fo = alarm_trip || coast_stop || motor_sel != 2'h0;
        ec = (m && ce && !fo) ? ec + 1 : 0;
        rc = (!m && cr && !fo && aresetn) ? rc + 1 : 0;
        cf = aresetn ? cf + out_current - cf / 16 : 0;
        if (!aresetn)
            m = 0;
        else if (fo)
            m = 1;
        else if (m && (output_shutdown || ec >= N))
            m = 0;
        else if (rc >= N)
            m = 1;
    end
    task automatic drv(input bit rn, vc, sh, input int f, rf, dt, tq, n);
        @(posedge aclk);
        run_cmd <= rn;
        vector_mode <= vc;
        output_shutdown <= sh;
        out_freq <= 16'(f);
        ref_speed <= 16'(rf);
        det_speed <= 16'(dt);
        torque_cmd <= 9'(tq);
        repeat (n) @(posedge aclk);
        #1;
        `CHK("brake_release_output", m, brake_release_output)
        if (n > 3)
            `CHK("brake_held", !m, brake_held)
    endtask : drv
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
        `CHK("bresp", r, bresp)
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        `CHK("rdata", d, rdata)
        `CHK("rresp", r, rresp)
        rready <= 1'h0;
    endtask : rd
    task complete_run;
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 8; i++)
            rd(8'(i * 4), rst[i], HBEL_RESP_OKAY);
        rd(8'h24, 32'h0, HBEL_RESP_SLVERR);
        wr(8'h24, 32'h1, HBEL_RESP_SLVERR);
        wr(HBEL_STATUS_OFS, 32'h1, HBEL_RESP_SLVERR);
        rd(HBEL_STATUS_OFS, 32'h0, HBEL_RESP_OKAY);
        wr(HBEL_SEL_OFS, 32'h3F, HBEL_RESP_OKAY);
        rd(HBEL_SEL_OFS, 32'(HBEL_SEL_MASK), HBEL_RESP_OKAY);
        wr(HBEL_ENG_TIME_OFS, 32'h2, HBEL_RESP_OKAY);
        wr(HBEL_REL_TIME_OFS, 32'h2, HBEL_RESP_OKAY);
        sel = 4;
        wr(HBEL_SEL_OFS, 32'h4, HBEL_RESP_OKAY);
        drv(1, 0, 0, 11 + rnd(90), 0, 0, 0, 4);
        drv(1, 0, 0, 11 + rnd(90), 0, 0, 0, 12);
        drv(0, 0, 0, rnd(10), 0, 0, 0, 4);
        drv(0, 0, 0, rnd(10), 0, 0, 0, 12);
        drv(1, 0, 0, 50, 0, 0, 0, 12);
        drv(0, 0, 0, 3, 0, 0, 0, 6);
        drv(1, 0, 0, 5, 0, 0, 0, 1);
        drv(0, 0, 0, 3, 0, 0, 0, 6);
        drv(0, 0, 0, 3, 0, 0, 0, 4);
        drv(1, 0, 0, 50, 0, 0, 0, 12);
        drv(0, 0, 0, 3, 0, 0, 0, 4);
        drv(0, 0, 1, 3, 0, 0, 0, 2);
        for (int b = 0; b < 16; b++)
        begin
            sel = 4 + (b & 1) + (b & 6) * 4;
            wr(HBEL_SEL_OFS, sel, HBEL_RESP_OKAY);
            drv(1, 1, 0, 0, 100, 100, 150, 12);
            drv(b[3], 1, 0, 0, rnd(20), rnd(20), 0, 12);
        end
        for (int k = 0; k < 5; k++)
        begin
            @(posedge aclk);
            alarm_trip <= (k == 0);
            coast_stop <= (k == 1);
            motor_sel <= 2'((k > 1) ? k - 1 : 0);
            drv(0, 0, 1, 3, 0, 0, 0, 3);
            @(posedge aclk);
            alarm_trip <= 1'h0;
            coast_stop <= 1'h0;
            motor_sel <= 2'h0;
            drv(0, 0, 0, 3, 0, 0, 0, 12);
        end
        sel = 0;
        wr(HBEL_SEL_OFS, 32'h0, HBEL_RESP_OKAY);
        @(posedge aclk);
        out_current <= 9'(150 + rnd(100));
        drv(1, 0, 0, 3, 0, 0, 0, 12);
        drv(1, 0, 0, 3, 0, 0, 0, 24);
        @(posedge aclk);
        out_current <= 9'h0;
        drv(0, 0, 0, 3, 0, 0, 0, 12);
        sel = 4;
        wr(HBEL_SEL_OFS, 32'h4, HBEL_RESP_OKAY);
        @(posedge aclk);
        out_current <= 9'(150 + rnd(100));
        drv(1, 0, 0, 3, 0, 0, 0, 10);
        complete_run();
    end
endmodule : hbel_top_tb
